// file: wde_exposure_ctrl.sv
/*
 * per-pixel multi-knee exposure control: apb registers, frame latch,
 * zone thresholds and exposure times.
 * assumes frame_start and global_shutter come from logic on the same clock.
 */
// Notes on behaviour
// - zone mode only applies while the sensor runs in global shutter mode
// - with zone mode off every pixel integrates for the full exposure
// - dark pixels integrate fully and fill output from zero to first limit
// - dark limit at 100 percent makes zone mode behave as disabled
// - bright exposure equals total exposure minus first knee offset
// - bright data lies between dark limit and bright limit
// - bright limit at 100 percent gives exactly two output zones
// - very bright exposure equals total minus second knee offset
// - very bright limit exceeds bright limit; very bright data between them
// - very bright limit at 100 percent leaves no ultra bright zone
// - ultra bright exposure equals total minus third knee offset
// - ultra bright data fills from very bright limit to full output
// - limits become counts proportional to full scale, 50 percent is 512
`timescale 1ns/1ps
module wde_exposure_ctrl (
    input wire logic clock,
    input wire logic reset_n,
    input wde_pkg::wde_apb_req_t apb_req,
    output wde_pkg::wde_apb_rsp_t apb_rsp,
    input wire logic frame_start,
    input wire logic global_shutter,
    output logic zone_mode_active,
    output logic config_error,
    output logic [wde_pkg::US_W-1:0] dark_exposure_us,
    output logic [wde_pkg::US_W-1:0] bright_exposure_time,
    output logic [wde_pkg::US_W-1:0] very_bright_exposure_us,
    output logic [wde_pkg::US_W-1:0] ultra_bright_exposure_us,
    output logic [wde_pkg::CNT_W-1:0] dark_zone_limit_count,
    output logic [wde_pkg::CNT_W-1:0] bright_zone_limit_count,
    output logic [wde_pkg::CNT_W-1:0] very_bright_zone_limit_count
);
    import wde_pkg::*;

    // ==========================================
    // state
    wde_set_t staged;
    wde_set_t applied;
    wde_set_t next_staged;
    wde_set_t next_applied;
    logic next_error;
    logic next_active;
    logic [US_W-1:0] next_bright;
    logic [US_W-1:0] next_vbright;
    logic [US_W-1:0] next_ubright;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;
    logic staged_ok;
    logic setup;
    logic wr_en;
    logic [PCT_W-1:0] eff_pct [3];
    logic [PCT_W-1:0] app_pct [3];
    logic [CNT_W-1:0] lim_count [3];

    // ==========================================
    // consistency check of the staged set
    function automatic logic set_ok(input wde_set_t s);
        logic ok;
        ok = (s.pct1 >= PCT_MIN) && (s.pct1 <= PCT_FULL);
        if (s.pct1 != PCT_FULL) begin
            ok = ok && (s.knee1 >= KNEE_MIN_US) && (s.knee1 < s.total);
            if (s.pct2 != PCT_FULL) begin
                ok = ok && (s.pct2 > s.pct1) && (s.knee2 > s.knee1)
                    && (s.knee2 < s.total);
                if (s.pct3 != PCT_FULL) begin
                    ok = ok && (s.pct3 > s.pct2) && (s.knee3 > s.knee2)
                        && (s.knee3 < s.total);
                end
            end else begin
                ok = ok && (s.pct3 == PCT_FULL);
            end
            ok = ok && (s.pct3 <= PCT_FULL) && (s.pct2 <= PCT_FULL);
        end
        return ok;
    endfunction

    assign staged_ok = set_ok(staged);
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;

    // ==========================================
    // register writes and frame latch
    always_comb begin
        next_staged = staged;
        next_applied = applied;
        next_error = config_error;
        if (wr_en) begin
            case (apb_req.paddr)
                OFS_CTRL: begin
                    next_staged.mode = apb_req.pwdata[0];
                end
                OFS_TOTAL: begin
                    next_staged.total = apb_req.pwdata[US_W-1:0];
                end
                OFS_ZONE: begin
                    next_staged.pct1 = apb_req.pwdata[ZONE_P1_LSB +: PCT_W];
                    next_staged.pct2 = apb_req.pwdata[ZONE_P2_LSB +: PCT_W];
                    next_staged.pct3 = apb_req.pwdata[ZONE_P3_LSB +: PCT_W];
                end
                OFS_KNEE1: begin
                    next_staged.knee1 = apb_req.pwdata[US_W-1:0];
                end
                OFS_KNEE2: begin
                    next_staged.knee2 = apb_req.pwdata[US_W-1:0];
                end
                OFS_KNEE3: begin
                    next_staged.knee3 = apb_req.pwdata[US_W-1:0];
                end
                OFS_STATUS: begin
                    if (apb_req.pwdata[STAT_ERROR]) begin
                        next_error = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (frame_start) begin
            if (staged_ok) begin
                next_applied = staged;
            end else begin
                next_error = 1'b1;
            end
        end
    end

    // ==========================================
    // exposure times and mode
    always_comb begin
        next_active = applied.mode && global_shutter && (applied.pct1 != PCT_FULL);
        next_bright = applied.total;
        next_vbright = applied.total;
        next_ubright = applied.total;
        if (next_active) begin
            next_bright = applied.total - applied.knee1;
            next_vbright = applied.total - applied.knee2;
            next_ubright = applied.total - applied.knee3;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            staged <= SET_RST;
            applied <= SET_RST;
            config_error <= 1'b0;
            zone_mode_active <= 1'b0;
            dark_exposure_us <= TOTAL_RST;
            bright_exposure_time <= TOTAL_RST;
            very_bright_exposure_us <= TOTAL_RST;
            ultra_bright_exposure_us <= TOTAL_RST;
        end else begin
            staged <= next_staged;
            applied <= next_applied;
            config_error <= next_error;
            zone_mode_active <= next_active;
            dark_exposure_us <= applied.total;
            bright_exposure_time <= next_bright;
            very_bright_exposure_us <= next_vbright;
            ultra_bright_exposure_us <= next_ubright;
        end
    end

    // ==========================================
    // zone thresholds
    assign app_pct[0] = applied.pct1;
    assign app_pct[1] = applied.pct2;
    assign app_pct[2] = applied.pct3;

    for (genvar i = 0; i < 3; i++) begin : g_zone
        assign eff_pct[i] = next_active ? app_pct[i] : PCT_FULL;
        wde_pct_count #(.CW(CNT_W)) u_cnt (
            .clock(clock),
            .reset_n(reset_n),
            .pct(eff_pct[i]),
            .count(lim_count[i])
        );
    end

    assign dark_zone_limit_count = lim_count[0];
    assign bright_zone_limit_count = lim_count[1];
    assign very_bright_zone_limit_count = lim_count[2];

    // ==========================================
    // apb slave, zero wait
    always_comb begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup) begin
            next_slverr = 1'b0;
            next_rdata = 32'h0000_0000;
            case (apb_req.paddr)
                OFS_CTRL: next_rdata[0] = staged.mode;
                OFS_TOTAL: next_rdata[US_W-1:0] = staged.total;
                OFS_ZONE: begin
                    next_rdata[ZONE_P1_LSB +: PCT_W] = staged.pct1;
                    next_rdata[ZONE_P2_LSB +: PCT_W] = staged.pct2;
                    next_rdata[ZONE_P3_LSB +: PCT_W] = staged.pct3;
                end
                OFS_KNEE1: next_rdata[US_W-1:0] = staged.knee1;
                OFS_KNEE2: next_rdata[US_W-1:0] = staged.knee2;
                OFS_KNEE3: next_rdata[US_W-1:0] = staged.knee3;
                OFS_STATUS: begin
                    next_rdata[STAT_SHUTTER] = global_shutter;
                    next_rdata[STAT_ACTIVE] = zone_mode_active;
                    next_rdata[STAT_ERROR] = config_error;
                end
                OFS_BRIGHT_T: next_rdata[US_W-1:0] = bright_exposure_time;
                OFS_VBRIGHT_T: next_rdata[US_W-1:0] = very_bright_exposure_us;
                OFS_UBRIGHT_T: next_rdata[US_W-1:0] = ultra_bright_exposure_us;
                default: next_slverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end else begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = rdata;
    assign apb_rsp.pslverr = slverr && apb_req.psel && apb_req.penable;

    // ==========================================
    // checks
    sequence s_latch_full3;
        (applied.mode && global_shutter && applied.pct1 != PCT_FULL
            && applied.pct3 == PCT_FULL) ##1 1'b1;
    endsequence

    sequence s_latch_full2;
        (applied.mode && global_shutter && applied.pct1 != PCT_FULL
            && applied.pct2 == PCT_FULL) ##1 1'b1;
    endsequence

    property p_shutter_gate;
        @(posedge clock) disable iff (!reset_n) !global_shutter |=> !zone_mode_active;
    endproperty
    a_shutter_gate: assert property (p_shutter_gate) else $error("no shutter");

    property p_off_full;
        @(posedge clock) disable iff (!reset_n) !zone_mode_active |->
            (bright_exposure_time == dark_exposure_us)
            && (ultra_bright_exposure_us == dark_exposure_us);
    endproperty
    a_off_full: assert property (p_off_full) else $error("short exposure while off");

    property p_dark_full;
        @(posedge clock) disable iff (!reset_n) 1'b1 |=> dark_exposure_us == $past(applied.total);
    endproperty
    a_dark_full: assert property (p_dark_full) else $error("dark time not total");

    property p_full_dark_off;
        @(posedge clock) disable iff (!reset_n) applied.pct1 == PCT_FULL |=> !zone_mode_active;
    endproperty
    a_full_dark_off: assert property (p_full_dark_off) else $error("active at full dark");

    property p_bright_time;
        @(posedge clock) disable iff (!reset_n) zone_mode_active |->
            bright_exposure_time == $past(applied.total) - $past(applied.knee1);
    endproperty
    a_bright_time: assert property (p_bright_time) else $error("bright time wrong");

    property p_vbright_time;
        @(posedge clock) disable iff (!reset_n) zone_mode_active |->
            very_bright_exposure_us == $past(applied.total) - $past(applied.knee2);
    endproperty
    a_vbright_time: assert property (p_vbright_time) else $error("vbright time wrong");

    property p_two_zones;
        @(posedge clock) disable iff (!reset_n) s_latch_full2 |->
            bright_zone_limit_count == FULL_SCALE_COUNT;
    endproperty
    a_two_zones: assert property (p_two_zones) else $error("bright limit not full");

    property p_three_zones;
        @(posedge clock) disable iff (!reset_n) s_latch_full3 |->
            very_bright_zone_limit_count == FULL_SCALE_COUNT;
    endproperty
    a_three_zones: assert property (p_three_zones) else $error("ultra zone present");

    property p_dark_scale;
        @(posedge clock) disable iff (!reset_n) next_active && applied.pct1 == 7'h32 |=>
            dark_zone_limit_count == 11'h200;
    endproperty
    a_dark_scale: assert property (p_dark_scale) else $error("half scale not 512");

    property p_refuse;
        @(posedge clock) disable iff (!reset_n) frame_start && !staged_ok |=>
            applied == $past(applied) && config_error;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad set applied");

    property p_frame_latch;
        @(posedge clock) disable iff (!reset_n) !frame_start |=> applied == $past(applied);
    endproperty
    a_frame_latch: assert property (p_frame_latch) else $error("set changed mid frame");

endmodule

// file: wde_pkg.sv
/*
 * constants, register map and carrier types for the exposure zone controller.
 * assumes a 10-bit pixel output and a 32-bit apb register bus.
 */
package wde_pkg;

    // ==========================================
    // widths
    localparam int PCT_W = 7;
    localparam int US_W = 24;
    localparam int CNT_W = 11;
    localparam int ADDR_W = 8;

    // ==========================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TOTAL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ZONE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_KNEE1 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_KNEE2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_KNEE3 = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_BRIGHT_T = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_VBRIGHT_T = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_UBRIGHT_T = 8'h24;

    // ==========================================
    // field positions
    localparam int ZONE_P1_LSB = 0;
    localparam int ZONE_P2_LSB = 8;
    localparam int ZONE_P3_LSB = 16;
    localparam int STAT_SHUTTER = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_ERROR = 2;

    // ==========================================
    // limits and scale
    localparam logic [PCT_W-1:0] PCT_MIN = 7'h0F;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
    localparam logic [US_W-1:0] KNEE_MIN_US = 24'h00_0002;
    localparam logic [CNT_W-1:0] FULL_SCALE_COUNT = 11'h400;

    // ==========================================
    // reset values
    localparam logic [US_W-1:0] TOTAL_RST = 24'h00_4E20;
    localparam logic [US_W-1:0] KNEE_RST = 24'h00_0000;

    typedef struct packed {
        logic [US_W-1:0] total;
        logic [US_W-1:0] knee1;
        logic [US_W-1:0] knee2;
        logic [US_W-1:0] knee3;
        logic [PCT_W-1:0] pct1;
        logic [PCT_W-1:0] pct2;
        logic [PCT_W-1:0] pct3;
        logic mode;
    } wde_set_t;

    localparam wde_set_t SET_RST = '{TOTAL_RST, KNEE_RST, KNEE_RST, KNEE_RST,
        PCT_FULL, PCT_FULL, PCT_FULL, 1'b0};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } wde_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wde_apb_rsp_t;

endpackage

// file: wde_pct_count.sv
/*
 * converts an output percentage into a registered count threshold.
 * assumes the percentage is already limited to 0..100.
 */
`timescale 1ns/1ps
module wde_pct_count #(
    parameter int CW = wde_pkg::CNT_W
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [wde_pkg::PCT_W-1:0] pct,
    output logic [CW-1:0] count
);
    import wde_pkg::*;

    logic [CW-1:0] next_count;
    logic [31:0] product;

    // ==========================================
    // scale against full range
    always_comb begin
        product = (32'(pct) * 32'(FULL_SCALE_COUNT)) / 32'(PCT_FULL);
        next_count = product[CW-1:0];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= CW'(FULL_SCALE_COUNT);
        end else begin
            count <= next_count;
        end
    end

endmodule

// file: wde_exposure_ctrl_tb_top.sv
/*
 * self-checking testbench for the exposure zone controller.
 * assumes the design answers apb with pready and applies staged settings at frame_start.
 */
`timescale 1ns/1ps
module wde_exposure_ctrl_tb_top;
    import wde_pkg::*;

    // ==========================================
    // signals
    logic clock;
    logic reset_n;
    wde_apb_req_t apb_req;
    wde_apb_rsp_t apb_rsp;
    logic frame_start;
    logic global_shutter;
    logic zone_mode_active;
    logic config_error;
    logic [US_W-1:0] dark_exposure_us;
    logic [US_W-1:0] bright_exposure_time;
    logic [US_W-1:0] very_bright_exposure_us;
    logic [US_W-1:0] ultra_bright_exposure_us;
    logic [CNT_W-1:0] dark_zone_limit_count;
    logic [CNT_W-1:0] bright_zone_limit_count;
    logic [CNT_W-1:0] very_bright_zone_limit_count;
    int err_total;
    int n_tests;
    logic [31:0] rd;
    logic serr;
    logic [31:0] bad_zone [8] = '{32'h0064_640e, 32'h0064_6432, 32'h0064_6432,
        32'h0064_2828, 32'h0055_4628, 32'h0055_4628, 32'h0055_6428, 32'h0046_4628};
    logic [23:0] bad_k1 [8] = '{24'h00_4650, 24'h00_0001, 24'h00_4e20, 24'h00_4650,
        24'h00_4650, 24'h00_4650, 24'h00_4650, 24'h00_4650};
    logic [23:0] bad_k2 [8] = '{24'h00_4d58, 24'h00_0000, 24'h00_0000, 24'h00_4d58,
        24'h00_4650, 24'h00_4d58, 24'h00_4d58, 24'h00_4d58};
    logic [23:0] bad_k3 [8] = '{24'h00_4e0c, 24'h00_0000, 24'h00_0000, 24'h00_4e0c,
        24'h00_4e0c, 24'h00_4e20, 24'h00_4e0c, 24'h00_4e0c};

    wde_exposure_ctrl dut (
        .clock(clock),
        .reset_n(reset_n),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .frame_start(frame_start),
        .global_shutter(global_shutter),
        .zone_mode_active(zone_mode_active),
        .config_error(config_error),
        .dark_exposure_us(dark_exposure_us),
        .bright_exposure_time(bright_exposure_time),
        .very_bright_exposure_us(very_bright_exposure_us),
        .ultra_bright_exposure_us(ultra_bright_exposure_us),
        .dark_zone_limit_count(dark_zone_limit_count),
        .bright_zone_limit_count(bright_zone_limit_count),
        .very_bright_zone_limit_count(very_bright_zone_limit_count)
    );

    always #5 clock = ~clock;

    // ==========================================
    // report and compare
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [23:0] tb, input logic [23:0] tvb,
            input logic [23:0] tub, input logic [10:0] c1, input logic [10:0] c2,
            input logic [10:0] c3);
        chk(32'(dark_exposure_us), 32'h0000_4e20);
        chk(32'(bright_exposure_time), 32'(tb));
        chk(32'(very_bright_exposure_us), 32'(tvb));
        chk(32'(ultra_bright_exposure_us), 32'(tub));
        chk(32'(dark_zone_limit_count), 32'(c1));
        chk(32'(bright_zone_limit_count), 32'(c2));
        chk(32'(very_bright_zone_limit_count), 32'(c3));
    endtask

    // ==========================================
    // apb master
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata, output logic err);
        int n;
        @(posedge clock);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wdata;
        @(posedge clock);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            err_total++;
            test_done();
        end
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        apb_xfer(1'b1, addr, data, d, e);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb_xfer(1'b0, addr, 32'h0000_0000, d, e);
        chk(d, exp);
        chk(32'(e), 32'h0000_0000);
    endtask

    // ==========================================
    // frame helpers
    task automatic frame;
        @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic set_cfg(input logic [31:0] zone, input logic [23:0] k1,
            input logic [23:0] k2, input logic [23:0] k3);
        wr(OFS_ZONE, zone);
        wr(OFS_KNEE1, 32'(k1));
        wr(OFS_KNEE2, 32'(k2));
        wr(OFS_KNEE3, 32'(k3));
        frame();
    endtask

    // ==========================================
    // main sequence
    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        apb_req = '0;
        frame_start = 1'b0;
        global_shutter = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk_out(24'h00_4e20, 24'h00_4e20, 24'h00_4e20, 11'h400, 11'h400, 11'h400);
        chk(32'(zone_mode_active), 32'h0000_0000);
        rdchk(OFS_TOTAL, 32'h0000_4e20);
        rdchk(OFS_ZONE, 32'h0064_6464);
        rdchk(OFS_KNEE1, 32'h0000_0000);
        apb_xfer(1'b0, 8'h28, 32'h0000_0000, rd, serr);
        chk({rd[30:0], serr}, 32'h0000_0001);
        // single knee start
        global_shutter <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0001);
        set_cfg(32'h0064_6432, 24'h00_4650, 24'h00_0000, 24'h00_0000);
        chk(32'(zone_mode_active), 32'h0000_0001);
        chk_out(24'h00_07d0, 24'h00_4e20, 24'h00_4e20, 11'h200, 11'h400, 11'h400);
        rdchk(OFS_STATUS, 32'h0000_0003);
        wr(OFS_BRIGHT_T, 32'h0000_1234);
        rdchk(OFS_BRIGHT_T, 32'h0000_07d0);
        // staged knee waits for the frame boundary
        wr(OFS_KNEE1, 32'h0000_4a38);
        repeat (4) @(posedge clock);
        chk(32'(bright_exposure_time), 32'h0000_07d0);
        frame();
        chk(32'(bright_exposure_time), 32'h0000_03e8);
        // rolling shutter suspends zone mode
        global_shutter <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'(zone_mode_active), 32'h0000_0000);
        chk_out(24'h00_4e20, 24'h00_4e20, 24'h00_4e20, 11'h400, 11'h400, 11'h400);
        rdchk(OFS_STATUS, 32'h0000_0000);
        global_shutter <= 1'b1;
        repeat (3) @(posedge clock);
        chk_out(24'h00_03e8, 24'h00_4e20, 24'h00_4e20, 11'h200, 11'h400, 11'h400);
        // two knee start, three zones
        set_cfg(32'h0064_4628, 24'h00_4650, 24'h00_4d58, 24'h00_0000);
        chk_out(24'h00_07d0, 24'h00_00c8, 24'h00_4e20, 11'h199, 11'h2cc, 11'h400);
        // three knees, four zones
        set_cfg(32'h0055_4628, 24'h00_4650, 24'h00_4d58, 24'h00_4e0c);
        chk_out(24'h00_07d0, 24'h00_00c8, 24'h00_0014, 11'h199, 11'h2cc, 11'h366);
        rdchk(OFS_VBRIGHT_T, 32'h0000_00c8);
        rdchk(OFS_UBRIGHT_T, 32'h0000_0014);
        rdchk(OFS_KNEE2, 32'h0000_4d58);
        rdchk(OFS_KNEE3, 32'h0000_4e0c);
        rdchk(OFS_CTRL, 32'h0000_0001);
        // inconsistent sets are refused and flagged
        for (int i = 0; i < 8; i++) begin
            set_cfg(bad_zone[i], bad_k1[i], bad_k2[i], bad_k3[i]);
            chk(32'(config_error), 32'h0000_0001);
            chk_out(24'h00_07d0, 24'h00_00c8, 24'h00_0014, 11'h199, 11'h2cc, 11'h366);
            wr(OFS_STATUS, 32'h0000_0004);
            rdchk(OFS_STATUS, 32'h0000_0003);
        end
        // full dark zone behaves as disabled
        set_cfg(32'h0064_6464, 24'h00_4650, 24'h00_4d58, 24'h00_4e0c);
        chk_out(24'h00_4e20, 24'h00_4e20, 24'h00_4e20, 11'h400, 11'h400, 11'h400);
        // mode off gives full exposure to every pixel
        set_cfg(32'h0055_4628, 24'h00_4650, 24'h00_4d58, 24'h00_4e0c);
        chk(32'(bright_zone_limit_count), 32'h0000_02cc);
        wr(OFS_CTRL, 32'h0000_0000);
        frame();
        chk(32'(zone_mode_active), 32'h0000_0000);
        chk_out(24'h00_4e20, 24'h00_4e20, 24'h00_4e20, 11'h400, 11'h400, 11'h400);
        test_done();
    end
endmodule
